// file: core/alarm_relay_control.sv
// Fault-to-relay logic: assignable relay, general relay, concentration
// average with low threshold, dryer lifetime fault, menu idle timeout.
// Assumes fault_in and menu_active are asynchronous pins, the measurement
// inputs come from logic on ref_clk, and an AXI4-Lite master sets it up.
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "alarm_relay_consts.svh"

module alarm_relay_control
   import alarm_relay_pkg::*;
#(
   parameter int W             = 24,
   parameter int MAX_DEPTH     = 16,
   parameter int ADDR_W        = 8,
   parameter int TICKS_PER_SEC = `SEC_NS / `CLK_PERIOD_NS,
   parameter int DW            = $clog2(MAX_DEPTH + 1)
)
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Fault pins and menu state
   input  wire logic [31:0]       fault_in,
   input  wire logic              menu_active,
   // Measurement logic
   input  wire logic              sample_valid,
   input  wire logic [W-1:0]      sample,
   input  wire logic [7:0]        dryer_capacity_pct,
   input  wire logic [15:0]       dryer_days_left,
   // Plant and display outputs
   output logic                   assign_relay,
   output logic                   general_relay,
   output logic [W-1:0]           avg_conc,
   output logic                   menu_exit,
   output logic                   dryer_restart
);

   ////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchronisers
   logic [1:0]  rst_sync_q;
   logic [31:0] fault_m_q;
   logic [31:0] fault_s_q;
   logic        menu_m_q;
   logic        menu_s_q;
   wire         rst_n = rst_sync_q[1];

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fault_m_q <= '0;
         fault_s_q <= '0;
         menu_m_q  <= 1'b0;
         menu_s_q  <= 1'b0;
      end
      else
      begin
         fault_m_q <= fault_in;
         fault_s_q <= fault_m_q;
         menu_m_q  <= menu_active;
         menu_s_q  <= menu_m_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0]     mask_q;
   gen_mode_t       mode_q;
   logic [15:0]     timeout_q;
   logic [DW-1:0]   depth_q;
   logic [W-1:0]    thresh_q;
   logic            rst_cmd_q;
   logic            replace_q;
   logic            aw_hold_q;
   logic            w_hold_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]     wdata_q;
   logic [3:0]      wstrb_q;
   logic            bvalid_q;
   logic [1:0]      bresp_q;
   logic            rvalid_q;
   logic [1:0]      rresp_q;
   logic [31:0]     rdata_q;

   // Write address and data are taken in either order and joined here
   wire aw_fire = awvalid && awready;
   wire w_fire  = wvalid && wready;
   wire wr_go   = (aw_hold_q || aw_fire) && (w_hold_q || w_fire);
   wire [ADDR_W-1:0] wr_addr = aw_hold_q ? awaddr_q : awaddr;
   wire [31:0]       wr_data = w_hold_q ? wdata_q : wdata;
   wire [3:0]        wr_strb = w_hold_q ? wstrb_q : wstrb;
   logic [31:0]      wmask;

   genvar b;
   generate
      for (b = 0; b < 4; b++)
      begin : g_lane
         assign wmask[8*b +: 8] = {8{wr_strb[b]}};
      end
   endgenerate

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction

   wire sel_mask    = wr_go && wr_addr == ADDR_W'(`OFS_MASK);
   wire sel_mode    = wr_go && wr_addr == ADDR_W'(`OFS_GEN_MODE);
   wire sel_timeout = wr_go && wr_addr == ADDR_W'(`OFS_TIMEOUT);
   wire sel_depth   = wr_go && wr_addr == ADDR_W'(`OFS_DEPTH);
   wire sel_thresh  = wr_go && wr_addr == ADDR_W'(`OFS_THRESH);
   wire sel_dryer   = wr_go && wr_addr == ADDR_W'(`OFS_DRYER);
   wire wr_hit      = sel_mask || sel_mode || sel_timeout || sel_depth ||
                      sel_thresh || sel_dryer;
   wire [31:0] m_mode = merge({30'h0, mode_q}, wr_data, wmask);
   wire [31:0] m_dry  = merge(32'h0, wr_data, wmask);
   wire mode_reset    = sel_mode && m_mode[1:0] == GEN_RESET;
   wire mode_legal    = m_mode[1:0] == GEN_LATCH ||
                        m_mode[1:0] == GEN_NONLATCH;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mask_q    <= `RST_MASK;
         mode_q    <= GEN_LATCH;
         timeout_q <= `RST_TIMEOUT;
         depth_q   <= DW'(`RST_DEPTH);
         thresh_q  <= '0;
         rst_cmd_q <= 1'b0;
         replace_q <= 1'b0;
      end
      else
      begin
         if (sel_mask)
            mask_q <= merge(mask_q, wr_data, wmask);
         // Reset code leaves the stored mode alone, an illegal code is dropped
         if (sel_mode && mode_legal)
            mode_q <= gen_mode_t'(m_mode[1:0]);
         if (sel_timeout)
            timeout_q <= 16'(merge({16'h0, timeout_q}, wr_data, wmask));
         if (sel_depth)
            depth_q <= DW'(merge(32'(depth_q), wr_data, wmask));
         if (sel_thresh)
            thresh_q <= W'(merge(32'(thresh_q), wr_data, wmask));
         rst_cmd_q <= mode_reset;
         replace_q <= sel_dryer && m_dry[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite handshakes
   assign awready = !aw_hold_q && !bvalid_q;
   assign wready  = !w_hold_q && !bvalid_q;
   assign arready = !rvalid_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rresp   = rresp_q;
   assign rdata   = rdata_q;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `RESP_OKAY;
      end
      else
      begin
         aw_hold_q <= !wr_go && (aw_hold_q || aw_fire);
         w_hold_q  <= !wr_go && (w_hold_q || w_fire);
         if (aw_fire)
            awaddr_q <= awaddr;
         if (w_fire)
         begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_go)
            bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         bvalid_q <= wr_go || (bvalid_q && !bready);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fault combination
   logic        conc_low_q;
   logic        dryer_fault_q;
   logic        latch_q;
   logic        assign_q;
   logic        general_q;
   logic [W-1:0] avg_q;
   logic        avg_valid_q;

   wire [31:0] internal = ({31'h0, conc_low_q} << `BIT_CONC_LOW) |
                          ({31'h0, dryer_fault_q} << `BIT_DRYER);
   wire [31:0] src      = ((fault_s_q & ~`INTERNAL_MASK) | internal) &
                          `FAULT_SRC_MASK;
   wire        gen_fault = |src;
   wire [31:0] fault_vec = src | ({31'h0, gen_fault} << `BIT_ANY) |
                           ({31'h0, 1'b1} << `BIT_POWER);
   // Bit 0 only sets polarity; the power-fail term never triggers
   wire        trig = |(fault_vec & mask_q & `TRIG_MASK);
   wire        dryer_cond = dryer_capacity_pct <= `DRYER_PCT_MIN ||
                            dryer_days_left == `DRYER_DAYS_END;
   wire        hold_latch = mode_q == GEN_LATCH && latch_q && !rst_cmd_q;

   // Set wins over the operator clear, so a fault still present survives
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         conc_low_q    <= 1'b0;
         dryer_fault_q <= 1'b0;
         latch_q       <= 1'b0;
         assign_q      <= 1'b0;
         general_q     <= 1'b0;
      end
      else
      begin
         conc_low_q    <= avg_valid_q && avg_q < thresh_q;
         dryer_fault_q <= dryer_cond ||
                          (dryer_fault_q && !replace_q && !rst_cmd_q);
         latch_q       <= gen_fault || (latch_q && !rst_cmd_q);
         assign_q      <= mask_q[0] ? !trig : trig;
         general_q     <= !(gen_fault || hold_latch);
      end
   end

   assign assign_relay  = assign_q;
   assign general_relay = general_q;
   assign avg_conc      = avg_q;
   assign dryer_restart = replace_q;

   ////////////////////////////////////////////////////////////////////////
   // Read mux
   wire [31:0] status = {26'h0, gen_fault, dryer_fault_q, conc_low_q,
                         latch_q, general_q, assign_q};
   wire ar_fire = arvalid && arready;
   wire rd_mask = araddr == ADDR_W'(`OFS_MASK);
   wire rd_mode = araddr == ADDR_W'(`OFS_GEN_MODE);
   wire rd_tmo  = araddr == ADDR_W'(`OFS_TIMEOUT);
   wire rd_dep  = araddr == ADDR_W'(`OFS_DEPTH);
   wire rd_thr  = araddr == ADDR_W'(`OFS_THRESH);
   wire rd_dry  = araddr == ADDR_W'(`OFS_DRYER);
   wire rd_st   = araddr == ADDR_W'(`OFS_STATUS);
   wire rd_flt  = araddr == ADDR_W'(`OFS_FAULTS);
   wire rd_avg  = araddr == ADDR_W'(`OFS_AVG);
   wire rd_hit  = rd_mask || rd_mode || rd_tmo || rd_dep || rd_thr ||
                  rd_dry || rd_st || rd_flt || rd_avg;
   wire [31:0] rd_data = rd_mask ? mask_q :
                         rd_mode ? {30'h0, mode_q} :
                         rd_tmo  ? {16'h0, timeout_q} :
                         rd_dep  ? 32'(depth_q) :
                         rd_thr  ? 32'(thresh_q) :
                         rd_st   ? status :
                         rd_flt  ? fault_vec :
                         rd_avg  ? 32'(avg_q) : 32'h0;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rvalid_q <= 1'b0;
         rresp_q  <= `RESP_OKAY;
         rdata_q  <= '0;
      end
      else
      begin
         if (ar_fire)
         begin
            rdata_q <= rd_data;
            rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         rvalid_q <= ar_fire || (rvalid_q && !rready);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Average and menu timer
   running_avg #(.W(W), .MAX_DEPTH(MAX_DEPTH), .DW(DW)) u_avg
   (
      .clk          (ref_clk),
      .rst_n        (rst_n),
      .sample_valid (sample_valid),
      .sample       (sample),
      .depth        (depth_q),
      .avg_q        (avg_q),
      .avg_valid_q  (avg_valid_q)
   );

   idle_timer #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_idle
   (
      .clk         (ref_clk),
      .rst_n       (rst_n),
      .menu_active (menu_s_q),
      .timeout     (timeout_q),
      .menu_exit_q (menu_exit)
   );

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sel_activate_a: assert property (trig && !mask_q[0] |=> assign_q)
      else $error("selected fault did not activate relay");
   failsafe_pol_a: assert property (!trig && mask_q[0] |=> assign_q)
      else $error("fail-safe relay not held active");
   any_fault_a: assert property (
      mask_q[`BIT_ANY] && !mask_q[`BIT_POWER] && gen_fault |=> assign_q)
      else $error("any-fault selection did not activate relay");
   unused_bits_a: assert property (
      !(|(fault_vec & mask_q & `TRIG_MASK)) && !mask_q[0] |=> !assign_q)
      else $error("unused mask bit moved relay");
   gen_drop_a: assert property (gen_fault |=> !general_q)
      else $error("general relay kept energized on fault");
   latch_hold_a: assert property (
      mode_q == GEN_LATCH && gen_fault && !rst_cmd_q
      ##1 mode_q == GEN_LATCH && !rst_cmd_q |=> !general_q)
      else $error("latched relay re-energized");
   nonlatch_back_a: assert property (
      mode_q == GEN_NONLATCH && !gen_fault |=> general_q)
      else $error("non-latching relay did not recover");
   reset_revert_a: assert property (
      mode_reset |=> mode_q == $past(mode_q) ##1 !latch_q || $past(gen_fault))
      else $error("mode reset did not revert or clear");
   conc_low_a: assert property (
      avg_valid_q && avg_q < thresh_q |=> conc_low_q)
      else $error("concentration-low fault missing");
   dryer_set_a: assert property (
      dryer_cond |=> dryer_fault_q && gen_fault)
      else $error("dryer fault not raised");
   dryer_clear_a: assert property (
      replace_q && !dryer_cond |=> !dryer_fault_q)
      else $error("dryer replace did not clear fault");
   tmo_off_a: assert property (
      timeout_q < `TIMEOUT_MIN && $past(timeout_q) < `TIMEOUT_MIN
      |-> !menu_exit)
      else $error("menu left with timeout disabled");

   latch_cov_c:  cover property (gen_fault ##1 !gen_fault ##1 rst_cmd_q);
   assign_cov_c: cover property (mask_q[0] && trig ##1 !assign_q);
   dryer_cov_c:  cover property (dryer_fault_q ##1 replace_q);
   exit_cov_c:   cover property (menu_exit);

endmodule // alarm_relay_control

// file: shared/alarm_relay_consts.svh
// Constants of the alarm and relay control block: register offsets,
// field masks, reset values and timing figures.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef ALARM_RELAY_CONSTS_SVH
`define ALARM_RELAY_CONSTS_SVH

// Register byte offsets
`define OFS_MASK       8'h00
`define OFS_GEN_MODE   8'h04
`define OFS_TIMEOUT    8'h08
`define OFS_DEPTH      8'h0c
`define OFS_THRESH     8'h10
`define OFS_DRYER      8'h14
`define OFS_STATUS     8'h18
`define OFS_FAULTS     8'h1c
`define OFS_AVG        8'h20

// AXI responses
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

// Reset values
`define RST_MASK       32'h00002000
`define RST_TIMEOUT    16'h003c
`define RST_DEPTH      16

// Fault vector layout
`define BIT_POWER      0
`define BIT_ANY        1
`define BIT_CONC_LOW   12
`define BIT_DRYER      27
`define INTERNAL_MASK  32'h08001003
`define FAULT_SRC_MASK 32'hffb9fffc
`define TRIG_MASK      32'hffb9fffe

// Thresholds and timing
`define DRYER_PCT_MIN  8'h05
`define DRYER_DAYS_END 16'h0000
`define TIMEOUT_MIN    16'h0005
`define CLK_PERIOD_NS  4
`define SEC_NS         1000000000

`endif

// file: shared/alarm_relay_pkg.sv
// Types shared by the alarm and relay control block.
// Assumes nothing of its surroundings.
package alarm_relay_pkg;

   typedef enum logic [1:0]
   {
      GEN_LATCH    = 2'b00,
      GEN_NONLATCH = 2'b01,
      GEN_RESET    = 2'b10
   } gen_mode_t;

endpackage

// file: core/running_avg.sv
// Running average of the most recent concentration samples.
// Assumes samples arrive on the system clock with a one-cycle strobe.
`timescale 1ns/1ps

module running_avg
   import alarm_relay_pkg::*;
#(
   parameter int W         = 24,
   parameter int MAX_DEPTH = 16,
   parameter int DW        = $clog2(MAX_DEPTH + 1)
)
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Samples and setting
   input  wire logic          sample_valid,
   input  wire logic [W-1:0]  sample,
   input  wire logic [DW-1:0] depth,
   // Result
   output logic      [W-1:0]  avg_q,
   output logic               avg_valid_q
);

   localparam int SW = W + DW;

   logic [W-1:0]  hist_q [MAX_DEPTH];
   logic [DW-1:0] fill_q;
   logic [DW-1:0] lim;
   logic [DW-1:0] eff;
   logic [SW-1:0] sum;

   ////////////////////////////////////////////////////////////////////////
   // History shift register, newest in entry 0
   genvar g;
   generate
      for (g = 0; g < MAX_DEPTH; g++)
      begin : g_hist
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               hist_q[g] <= '0;
            else if (sample_valid)
               hist_q[g] <= (g == 0) ? sample : hist_q[(g == 0) ? 0 : g-1];
         end
      end
   endgenerate

   // Zero or oversize depth is clamped, a partly filled history averages
   // only what it holds, so start-up shows no dip toward zero.
   assign lim = (depth == '0) ? DW'(1) :
                (depth > DW'(MAX_DEPTH)) ? DW'(MAX_DEPTH) : depth;
   assign eff = (fill_q < lim) ? fill_q : lim;

   always_comb
   begin
      sum = '0;
      for (int i = 0; i < MAX_DEPTH; i++)
         if (i < int'(eff))
            sum = sum + SW'(hist_q[i]);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fill_q      <= '0;
         avg_q       <= '0;
         avg_valid_q <= 1'b0;
      end
      else
      begin
         if (sample_valid && fill_q != DW'(MAX_DEPTH))
            fill_q <= fill_q + DW'(1);
         if (eff != '0)
            avg_q <= W'(sum / SW'(eff));
         avg_valid_q <= (eff != '0);
      end
   end

endmodule // running_avg

// file: core/idle_timer.sv
// Menu idle timeout: one pulse after the set number of seconds in menu.
// Assumes menu_active is already synchronised to the clock.
`timescale 1ns/1ps
`include "alarm_relay_consts.svh"

module idle_timer
   import alarm_relay_pkg::*;
#(
   parameter int TICKS_PER_SEC = `SEC_NS / `CLK_PERIOD_NS
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Menu state and setting
   input  wire logic        menu_active,
   input  wire logic [15:0] timeout,
   // Return to normal operation
   output logic             menu_exit_q
);

   logic [31:0] pre_q;
   logic [15:0] sec_q;
   logic        fired_q;
   wire         enabled = (timeout >= `TIMEOUT_MIN);
   wire         tick    = (pre_q == 32'(TICKS_PER_SEC - 1));
   wire         expire  = menu_active && enabled && !fired_q && tick &&
                          (sec_q + 16'h0001 >= timeout);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_q       <= '0;
         sec_q       <= '0;
         fired_q     <= 1'b0;
         menu_exit_q <= 1'b0;
      end
      else
      begin
         // Leaving the menu restarts the count from zero
         pre_q       <= (!menu_active || tick) ? '0 : pre_q + 32'h1;
         sec_q       <= !menu_active ? '0 :
                        (tick && !fired_q) ? sec_q + 16'h0001 : sec_q;
         fired_q     <= menu_active && (fired_q || expire);
         menu_exit_q <= expire;
      end
   end

endmodule // idle_timer

// file: testbench/plant_alarm.sv
// Plant side of the relay contacts: alarm horn and trip lamp.
// Assumes relay levels from the block, 1 = activated or energized.
`timescale 1ns/1ps

module plant_alarm
(
   // Relay contacts
   input  wire logic assign_relay,
   input  wire logic general_relay,
   // Plant indications
   output logic      horn,
   output logic      trip
);
   // A dropped general relay trips, so a dead supply trips as well
   assign horn = assign_relay;
   assign trip = !general_relay;
endmodule // plant_alarm

// file: testbench/tb_alarm_relay_control.sv
// Self-checking bench of the alarm and relay control block.
// Assumes the block, its package and constants header, and plant_alarm.
`timescale 1ns/1ps
`include "alarm_relay_consts.svh"

module tb_alarm_relay_control
   import alarm_relay_pkg::*;
;
   logic        ref_clk = 1'b0, nrst = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        menu_active = 0, sample_valid = 0;
   logic [31:0] wdata = 32'h0, fault_in = 32'h0, rd_d;
   logic [23:0] sample = 24'h0;
   logic [7:0]  dryer_capacity_pct = 8'h32;
   logic [15:0] dryer_days_left = 16'h0064;
   logic [1:0]  bresp, rresp, rd_r, wr_b;
   logic [31:0] rdata;
   logic [23:0] avg_conc;
   logic        awready, wready, bvalid, arready, rvalid, assign_relay;
   logic        general_relay, menu_exit, dryer_restart, horn, trip;
   int          n_errors = 0, n_checks = 0, cycles = 0, n_restart = 0;

   // Short seconds keep the idle timeout inside the run
   alarm_relay_control #(.TICKS_PER_SEC(10)) DUT
   (
      .ref_clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .fault_in, .menu_active,
      .sample_valid, .sample, .dryer_capacity_pct, .dryer_days_left,
      .assign_relay, .general_relay, .avg_conc, .menu_exit, .dryer_restart
   );
   plant_alarm plant (.assign_relay, .general_relay, .horn, .trip);

   always #2 ref_clk = ~ref_clk;
   always @(negedge ref_clk) if (dryer_restart === 1'b1) n_restart++;

   task automatic conclude;
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         conclude();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      check({31'h0, got}, {31'h0, exp});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // Ready is sampled mid-cycle, so it is the value seen at the next edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(negedge ref_clk);
         ta = awready;
         tw = wready;
         tb = bvalid;
         wr_b = bresp;
         @(posedge ref_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      while (!tb);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      logic ta, tv;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(negedge ref_clk);
         ta = arready;
         tv = rvalid;
         rd_d = rdata;
         rd_r = rresp;
         @(posedge ref_clk);
         if (ta) arvalid <= 1'b0;
      end
      while (!tv);
      rready <= 1'b0;
   endtask

   task automatic stat(input int b, input logic e);
      rd(`OFS_STATUS);
      chk1(rd_d[b], e);
   endtask

   task automatic smp(input logic [23:0] v);
      @(posedge ref_clk);
      sample <= v;
      sample_valid <= 1'b1;
      @(posedge ref_clk);
      sample_valid <= 1'b0;
   endtask

   task automatic t_general;
      fault_in <= 32'h4;
      cyc(5);
      chk1(trip, 1'b1);
      fault_in <= 32'h0;
      cyc(5);
      chk1(general_relay, 1'b0);
      wr(`OFS_GEN_MODE, {30'h0, GEN_RESET});
      check({30'h0, wr_b}, {30'h0, `RESP_OKAY});
      cyc(4);
      chk1(general_relay, 1'b1);
      rd(`OFS_GEN_MODE);
      check(rd_d, 32'h0);
      wr(`OFS_GEN_MODE, {30'h0, GEN_NONLATCH});
      wr(`OFS_GEN_MODE, 32'h3);
      rd(`OFS_GEN_MODE);
      check(rd_d, 32'h1);
      fault_in <= 32'h4;
      cyc(5);
      chk1(general_relay, 1'b0);
      fault_in <= 32'h0;
      cyc(5);
      chk1(general_relay, 1'b1);
   endtask

   task automatic t_mask;
      for (int i = 2; i < 32; i++)
      begin
         if (i == 12 || i == 27) continue;
         wr(`OFS_MASK, 32'h1 << i);
         fault_in <= 32'h1 << i;
         cyc(5);
         chk1(horn, !(i inside {17, 18, 22}));
         fault_in <= 32'h0;
         cyc(5);
      end
      wr(`OFS_MASK, 32'h2);
      fault_in <= 32'h80000;
      cyc(5);
      chk1(horn, 1'b1);
      wr(`OFS_MASK, 32'h2001);
      fault_in <= 32'h2000;
      cyc(5);
      chk1(horn, 1'b0);
      fault_in <= 32'h0;
      cyc(5);
      chk1(horn, 1'b1);
   endtask

   task automatic t_avg;
      wr(`OFS_DEPTH, 32'h2);
      smp(24'h0a);
      smp(24'h14);
      smp(24'h1e);
      cyc(4);
      check({8'h0, avg_conc}, 32'h19);
      stat(3, 1'b0);
      wr(`OFS_THRESH, 32'h1a);
      cyc(3);
      stat(3, 1'b1);
      wr(`OFS_THRESH, 32'h19);
      cyc(3);
      stat(3, 1'b0);
   endtask

   task automatic t_dryer;
      dryer_capacity_pct <= 8'h05;
      cyc(3);
      stat(4, 1'b1);
      chk1(general_relay, 1'b0);
      dryer_capacity_pct <= 8'h06;
      wr(`OFS_DRYER, 32'h1);
      cyc(3);
      check(n_restart, 32'h1);
      stat(4, 1'b0);
      dryer_days_left <= 16'h0000;
      cyc(3);
      stat(4, 1'b1);
      dryer_days_left <= 16'h0064;
   endtask

   task automatic t_menu(input logic [15:0] t, input int e);
      int c;
      c = 0;
      wr(`OFS_TIMEOUT, {16'h0, t});
      menu_active <= 1'b1;
      repeat (90)
      begin
         @(negedge ref_clk);
         if (menu_exit === 1'b1) c++;
      end
      @(posedge ref_clk);
      menu_active <= 1'b0;
      check(c, e);
      cyc(3);
   endtask

   initial
   begin
      cyc(10);
      chk1(general_relay, 1'b0);
      nrst <= 1'b1;
      cyc(5);
      chk1(general_relay, 1'b1);
      rd(`OFS_MASK);
      check(rd_d, `RST_MASK);
      rd(8'h40);
      check({30'h0, rd_r}, {30'h0, `RESP_SLVERR});
      wr(8'h40, 32'h1);
      check({30'h0, wr_b}, {30'h0, `RESP_SLVERR});
      t_general();
      t_mask();
      t_avg();
      t_dryer();
      t_menu(16'h0005, 1);
      t_menu(16'h0004, 0);
      conclude();
   end
endmodule // tb_alarm_relay_control
